// ---- pkg/aasp_pkg.sv ----
// package: formats, widths and constants of the audio serial port
package aasp_pkg;
  localparam int WORD_W      = 32;
  localparam int BITCNT_W    = 5;
  localparam int CHAN_N      = 4;
  localparam int SLOT_W      = 8;
  localparam int FIFO_DEPTH  = 4;
  localparam int FRAME_W     = WORD_W * CHAN_N;
  localparam logic [BITCNT_W-1:0] MSB_IDX = 5'h1f;
  localparam logic [SLOT_W-1:0] SLOT_RST  = 8'h00;

  typedef enum logic [2:0] {
    FMT_RIGHT = 3'b000,
    FMT_LEFT  = 3'b001,
    FMT_I2S   = 3'b010,
    FMT_PCMA  = 3'b011,
    FMT_PCMB  = 3'b100,
    FMT_SLOT  = 3'b101
  } aasp_fmt_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_SHIFT = 2'b10
  } aasp_state_t;

  typedef struct packed {
    logic [WORD_W-1:0] ch4;
    logic [WORD_W-1:0] ch3;
    logic [WORD_W-1:0] ch2;
    logic [WORD_W-1:0] ch1;
  } aasp_frame_t;

  typedef struct packed {
    aasp_fmt_t         fmt;
    logic              tdm;
    logic [SLOT_W-1:0] slotStart;
    logic [1:0]        selA;
    logic [1:0]        selB;
  } aasp_cfg_t;
endpackage : aasp_pkg

// ---- logic/aasp_fifo.sv ----
// fifo of frames between the converter side and the serial shifter
`timescale 1ns/10ps
module aasp_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  wire              doWr = inValid && inReady;
  wire              doRd = outValid && outReady;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem_r[rdPtr_r];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doWr) wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      if (doRd) rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      count_r <= count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end

  always_ff @(posedge clk) begin
    if (doWr) mem_r[wrPtr_r] <= inData;
  end
endmodule : aasp_fifo

// ---- logic/aasp_serial_port.sv ----
// serial audio output port: shifts four-channel frames out against bit clock and frame sync
// How it works
// R1: in right-aligned two-channel mode the last bit leaves on the final rising edge before sync turns.
// R2: in right and left aligned modes left data goes while sync is high, right while it is low.
// R3: in left-aligned mode the first bit leaves on the first rising edge after a sync change.
// R4: in I2S mode the first bit leaves on the second rising edge and left data goes while sync is low.
// R5: in pulse mode A the left word starts on the second rising edge and right follows at once.
// R6: in pulse mode B the left word starts on the first rising edge and right follows at once.
// R7: a two-channel slot mode delays the data and may swap or duplicate the channels.
// R8: in four-channel right-aligned mode channels 1,3 go with sync high and 2,4 with sync low, ending at the turn.
// R9: in four-channel left-aligned mode each half starts on the first rising edge after the turn.
// R10: in four-channel I2S mode each half starts on the second rising edge, channels 1,3 with sync low.
// R11: in four-channel pulse mode A channels 1 to 4 go back to back from the second rising edge.
// R12: in four-channel pulse mode B channels 1 to 4 go back to back from the first rising edge.
// R13: a four-channel offset mode delays the data and may swap or duplicate channels.
// R14: the receiver samples each bit on the falling edge opposite to its launch.
// R15: the slot start is a count of bit clocks after the pulse, and the data pin is released elsewhere.
`timescale 1ns/10ps
module aasp_serial_port (
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic                                  bitClk,
  input  wire logic                                  frameSync,
  input  wire aasp_pkg::aasp_cfg_t                   cfg,
  input  wire logic [aasp_pkg::BITCNT_W-1:0]         wordLenM1,
  input  wire aasp_pkg::aasp_frame_t                 sampleIn,
  input  wire logic                                  sampleValid,
  output logic                                       sampleReady,
  output logic                                       dataOut,
  output logic                                       dataOe,
  output logic                                       underrun
);
  // two flip-flops per pin before anything reads them
  logic [1:0] bclkSync_r;
  logic [1:0] fsSync_r;
  logic       bclkDly_r;
  logic       fsDly_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bclkSync_r <= 2'b00;
      fsSync_r   <= 2'b00;
      bclkDly_r  <= 1'b0;
      fsDly_r    <= 1'b0;
    end else begin
      bclkSync_r <= {bclkSync_r[0], bitClk};
      fsSync_r   <= {fsSync_r[0], frameSync};
      bclkDly_r  <= bclkSync_r[1];
      fsDly_r    <= fsSync_r[1];
    end
  end

  wire bclkRise = bclkSync_r[1] && !bclkDly_r;
  wire fsLvl    = fsSync_r[1];

  // frame sync is sampled on bit-clock rises so a change is seen at the first rise after it
  logic fsAtRise_r;
  wire  fsEdge   = bclkRise && (fsLvl != fsAtRise_r);
  wire  fsRiseEv = fsEdge && fsLvl;

  // four frames buffered ahead; the shifter holds the frame being sent
  aasp_pkg::aasp_frame_t fifoData;
  logic                  fifoValid;
  logic                  fifoTake;

  aasp_fifo #(
    .WIDTH (aasp_pkg::FRAME_W),
    .DEPTH (aasp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inData   (sampleIn),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoTake)
  );

  // channel words of the current frame, indexed 0..3 for channels 1..4
  logic [aasp_pkg::WORD_W-1:0] chan_r [aasp_pkg::CHAN_N];
  logic [aasp_pkg::WORD_W-1:0] fifoWord [aasp_pkg::CHAN_N];
  assign fifoWord[0] = fifoData.ch1;
  assign fifoWord[1] = fifoData.ch2;
  assign fifoWord[2] = fifoData.ch3;
  assign fifoWord[3] = fifoData.ch4;

  // formats sort into sync-level halves (right/left/i2s) and pulse trains (pcm a/b/slot)
  wire isRight = cfg.fmt == aasp_pkg::FMT_RIGHT;
  wire isI2s   = cfg.fmt == aasp_pkg::FMT_I2S;
  wire isHalf  = isRight || (cfg.fmt == aasp_pkg::FMT_LEFT) || isI2s;
  wire isSlot  = cfg.fmt == aasp_pkg::FMT_SLOT;
  wire oneSkip = isI2s || (cfg.fmt == aasp_pkg::FMT_PCMA); // R4 R5 R10 R11

  // words per burst: 1 or 2 per half, 2 or 4 per pulse frame
  wire [2:0] burstWords = isHalf ? (cfg.tdm ? 3'd2 : 3'd1) : (cfg.tdm ? 3'd4 : 3'd2);

  // right-aligned needs half length in bit clocks, measured from the previous half
  logic [7:0] halfLen_r;
  logic [7:0] halfCnt_r;
  wire  [7:0] burstBits = 8'((32'(burstWords)) * (32'(wordLenM1) + 32'd1));
  wire  [7:0] rightSkip = (halfLen_r > burstBits) ? (halfLen_r - burstBits) : 8'h00;

  // delay in bit clocks from the sync event to the first launch
  wire [7:0] startDly = isRight ? rightSkip :                        // R1 R8
                        isSlot  ? cfg.slotStart :                    // R7 R13 R15
                        oneSkip ? 8'h01 : 8'h00;                     // R3 R6 R9 R12

  // half-frame phase: high carries ch1/ch3 in right/left, low carries them in i2s
  wire phaseA = isI2s ? !fsLvl : fsLvl;                              // R2 R4 R8 R9 R10
  wire startEv = isHalf ? fsEdge : fsRiseEv;

  // word order within a burst, with slot-mode swap/duplicate through selA/selB
  function automatic logic [1:0] wordIdx(input logic [2:0] k, input logic ph, input logic half,
                                         input logic slot, input logic tdm,
                                         input logic [1:0] sa, input logic [1:0] sb);
    logic [1:0] r;
    r = 2'(k);
    if (half) r = tdm ? {k[0], !ph} : {1'b0, !ph};                   // R8 R9 R10
    else if (slot && !tdm) r = k[0] ? sb : sa;                       // R7
    else if (slot && k == 3'd0) r = sa;                              // R13
    else if (slot && k == 3'd1) r = sb;                              // R13
    return r;
  endfunction

  aasp_pkg::aasp_state_t state_r;
  logic [7:0]                   dly_r;
  logic [aasp_pkg::BITCNT_W-1:0] bit_r;
  logic [2:0]                   word_r;
  logic                         phase_r;
  logic                         dataOut_r;
  logic                         dataOe_r;
  logic                         underrun_r;

  // a new frame is pulled at the start of each pulse frame, or of the first half in level formats
  wire   frameStart = startEv && (!isHalf || phaseA);
  assign fifoTake   = frameStart && fifoValid;

  wire [1:0] curIdx = wordIdx(word_r, phase_r, isHalf, isSlot, cfg.tdm, cfg.selA, cfg.selB);
  wire [aasp_pkg::WORD_W-1:0] curWord = chan_r[curIdx];
  // msb first: the word is left-aligned at bit 31, word length set by wordLenM1
  wire [aasp_pkg::BITCNT_W-1:0] bitPos = aasp_pkg::MSB_IDX - (wordLenM1 - bit_r);
  wire lastBit  = bit_r == '0;
  wire lastWord = word_r == burstWords - 3'd1;
  // shift step shared by the last delay rise and the shift state
  wire [aasp_pkg::BITCNT_W-1:0] bitNxt  = lastBit ? wordLenM1 : bit_r - 1'b1;
  wire [2:0]                    wordNxt = lastBit ? word_r + 3'd1 : word_r;
  wire                          doneNxt = lastBit && lastWord;
  // one-bit words finish the first word on the launch rise itself
  wire                          oneBitW = wordLenM1 == '0;
  wire [1:0] firstIdx = wordIdx(3'd0, phaseA, isHalf, isSlot, cfg.tdm, cfg.selA, cfg.selB);
  // the frame may be loaded on this very rise, so take the msb from the fifo side then
  wire firstBit = fifoTake ? fifoWord[firstIdx][aasp_pkg::MSB_IDX]
                           : chan_r[firstIdx][aasp_pkg::MSB_IDX];

  genvar gi;
  generate
    for (gi = 0; gi < aasp_pkg::CHAN_N; gi++) begin : g_chan
      always_ff @(posedge clk or posedge rst) begin
        if (rst) chan_r[gi] <= '0;
        else if (fifoTake) chan_r[gi] <= fifoWord[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fsAtRise_r <= 1'b0;
      halfLen_r  <= 8'h00;
      halfCnt_r  <= 8'h00;
    end else if (bclkRise) begin
      fsAtRise_r <= fsLvl;
      halfCnt_r  <= fsEdge ? 8'h01 : halfCnt_r + 8'h01;
      if (fsEdge) halfLen_r <= halfCnt_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      underrun_r <= 1'b0;
    end else begin
      underrun_r <= frameStart && !fifoValid;
    end
  end

  // launch happens on bit-clock rises so the receiver can sample on the fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r   <= aasp_pkg::ST_IDLE;
      dly_r     <= 8'h00;
      bit_r     <= '0;
      word_r    <= 3'd0;
      phase_r   <= 1'b0;
      dataOut_r <= 1'b0;
      dataOe_r  <= 1'b0;
    end else if (bclkRise) begin
      if (startEv) begin
        phase_r <= phaseA;
        word_r  <= 3'd0;
        bit_r   <= wordLenM1;
        dly_r   <= startDly;
        if (startDly == 8'h00) begin
          // msb leaves on this rise; holding it in the register keeps it for the whole bit
          dataOut_r <= firstBit;                                     // R3 R6 R9 R12
          dataOe_r  <= 1'b1;
          bit_r     <= oneBitW ? wordLenM1 : wordLenM1 - 5'h01;
          word_r    <= oneBitW ? 3'd1 : 3'd0;
          state_r   <= (oneBitW && burstWords == 3'd1) ? aasp_pkg::ST_IDLE : aasp_pkg::ST_SHIFT;
        end else begin
          state_r  <= aasp_pkg::ST_DELAY;
          dataOe_r <= 1'b0;                                          // R15
        end
      end else begin
        case (state_r)
          aasp_pkg::ST_IDLE: begin
            dataOe_r <= 1'b0;                                        // R15
          end
          aasp_pkg::ST_DELAY: begin
            dly_r <= dly_r - 8'h01;
            // the rise that ends the delay launches the msb, not the one after it
            if (dly_r == 8'h01) begin                                // R1 R4 R5 R10 R11
              dataOut_r <= curWord[bitPos];
              dataOe_r  <= 1'b1;
              bit_r     <= bitNxt;
              word_r    <= wordNxt;
              state_r   <= doneNxt ? aasp_pkg::ST_IDLE : aasp_pkg::ST_SHIFT;
            end
          end
          aasp_pkg::ST_SHIFT: begin
            dataOut_r <= curWord[bitPos];                            // R14
            dataOe_r  <= 1'b1;
            bit_r     <= bitNxt;
            word_r    <= wordNxt;                                    // R5 R6 R11 R12
            if (doneNxt) state_r <= aasp_pkg::ST_IDLE;
          end
          default: state_r <= aasp_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // zero-delay starts launch on the same rise as the detected sync change
  wire launchNow = bclkRise && startEv && (startDly == 8'h00);

  assign dataOut  = dataOut_r;                                       // R3 R6 R9 R12
  assign dataOe   = dataOe_r;                                        // R15
  assign underrun = underrun_r;

  AST_MSB_AT_ONCE: assert property (@(posedge clk) disable iff (rst)
    launchNow |=> (dataOe && dataOut == $past(firstBit)))
    else $error("msb not launched on the sync rise"); // R3

  AST_OE_OFF_IDLE: assert property (@(posedge clk) disable iff (rst)
    (state_r == aasp_pkg::ST_IDLE && bclkRise && !startEv) |=> !dataOe_r)
    else $error("data pin driven outside own slot"); // R15
  AST_DELAY_HOLDS_OFF: assert property (@(posedge clk) disable iff (rst)
    (state_r == aasp_pkg::ST_DELAY) |-> !dataOe_r)
    else $error("data pin driven during slot delay"); // R7
  AST_SKIP_ONE: assert property (@(posedge clk) disable iff (rst)
    (bclkRise && startEv && oneSkip && !isSlot) |=> (state_r == aasp_pkg::ST_DELAY))
    else $error("second-edge formats did not wait one bit clock"); // R4
  AST_FIRST_EDGE: assert property (@(posedge clk) disable iff (rst)
    (bclkRise && startEv && !isRight && !oneSkip && !isSlot) |=> ##1 dataOe)
    else $error("first-edge format did not launch at once"); // R3
  AST_SLOT_DELAY: assert property (@(posedge clk) disable iff (rst)
    (bclkRise && startEv && isSlot && cfg.slotStart != 8'h00) |=> dly_r == $past(cfg.slotStart))
    else $error("slot delay not loaded from start count"); // R13
  AST_WORD_STEP: assert property (@(posedge clk) disable iff (rst)
    (bclkRise && !startEv && state_r == aasp_pkg::ST_SHIFT && lastBit && !lastWord)
      |=> word_r == $past(word_r) + 3'd1 && state_r == aasp_pkg::ST_SHIFT)
    else $error("next word did not follow last bit"); // R11
  AST_PHASE_I2S: assert property (@(posedge clk) disable iff (rst)
    (bclkRise && startEv && isI2s) |=> phase_r == !$past(fsLvl))
    else $error("i2s phase not inverted"); // R10
  AST_PHASE_LVL: assert property (@(posedge clk) disable iff (rst)
    (bclkRise && startEv && isHalf && !isI2s) |=> phase_r == $past(fsLvl))
    else $error("left data not tied to sync high"); // R2
  AST_RIGHT_END: assert property (@(posedge clk) disable iff (rst)
    (bclkRise && startEv && isRight) |=> dly_r == $past(rightSkip))
    else $error("right-aligned delay not from half length"); // R1
endmodule : aasp_serial_port

// ---- verif/aasp_host_model.sv ----
// host receiver model: makes bit clock and frame sync, samples the data line
`timescale 1ns/10ps
module aasp_host_model (
  output logic      bitClk,
  output logic      frameSync,
  input  wire logic dataOut,
  input  wire logic dataOe
);
  logic capBit [0:95];
  logic capOe  [0:95];
  logic lastVal;
  logic lineLvl;

  // a released line shows the inverse of its last level, so stale data cannot pass
  assign lineLvl = dataOe ? dataOut : ~lastVal;

  initial begin
    bitClk    = 1'b0;
    frameSync = 1'b0;
    lastVal   = 1'b0;
  end

  // bit clock runs only inside frames and stands still low between runs
  task automatic run(input int nFrames, input int half, input bit pulse);
    for (int f = 0; f < nFrames; f++) begin
      for (int i = 0; i < 2 * half; i++) begin
        frameSync = pulse ? (i == 0) : (i < half);
        #80 bitClk = 1'b1;
        #80 bitClk = 1'b0;
        capBit[i] = lineLvl;
        capOe[i]  = dataOe;
        lastVal   = lineLvl;
      end
    end
    frameSync = 1'b0;
  endtask : run
endmodule : aasp_host_model

// ---- verif/testbench.sv ----
// self-checking bench: frames through the port in every format, checked at the host
`timescale 1ns/10ps
module testbench;
  logic                          clk;
  logic                          rst;
  logic                          bitClk;
  logic                          frameSync;
  aasp_pkg::aasp_cfg_t           cfg;
  logic [aasp_pkg::BITCNT_W-1:0] wordLenM1;
  aasp_pkg::aasp_frame_t         sampleIn;
  logic                          sampleValid;
  logic                          sampleReady;
  logic                          dataOut;
  logic                          dataOe;
  logic                          underrun;
  int                            error_cnt;
  int                            total_checks;
  int                            runCnt;
  int                            runBase;
  int                            pushed;
  aasp_pkg::aasp_frame_t         frameD;

  aasp_serial_port i_dut (
    .clk(clk), .rst(rst), .bitClk(bitClk), .frameSync(frameSync), .cfg(cfg),
    .wordLenM1(wordLenM1), .sampleIn(sampleIn), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .dataOut(dataOut), .dataOe(dataOe), .underrun(underrun)
  );

  aasp_host_model i_host (
    .bitClk(bitClk), .frameSync(frameSync), .dataOut(dataOut), .dataOe(dataOe)
  );

  always #10 clk = ~clk;

  always @(posedge clk) begin
    if (underrun === 1'b1) runCnt <= runCnt + 1;
  end

  task chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : chk

  task finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  // offers the same frame until the buffer refuses
  task fill;
    pushed = 0;
    @(negedge clk);
    sampleIn = frameD;
    while (sampleReady === 1'b1 && pushed < 8) begin
      sampleValid = 1'b1;
      @(negedge clk);
      pushed++;
    end
    sampleValid = 1'b0;
    chk(sampleReady === 1'b0, "buffer not refusing when full");
  endtask : fill

  // 16-bit words in 32-bit halves (48 in tdm) so right and left alignment differ
  task automatic check_fmt(input aasp_pkg::aasp_fmt_t f, input logic t, input int s,
                           input logic [1:0] a, input logic [1:0] b);
    int          h;
    int          n;
    int          base;
    int          phA;
    int          pos;
    int          c;
    logic        pulse;
    logic        eb [0:95];
    logic        eo [0:95];
    logic [31:0] w  [0:3];
    w[0]  = frameD.ch1;
    w[1]  = frameD.ch2;
    w[2]  = frameD.ch3;
    w[3]  = frameD.ch4;
    n     = t ? 4 : 2;
    h     = t ? 48 : 32;
    pulse = f inside {aasp_pkg::FMT_PCMA, aasp_pkg::FMT_PCMB, aasp_pkg::FMT_SLOT};
    phA   = (f == aasp_pkg::FMT_I2S) ? h : 0;
    base  = (f == aasp_pkg::FMT_RIGHT) ? h - n * 8 :
            (f == aasp_pkg::FMT_I2S || f == aasp_pkg::FMT_PCMA) ? 1 :
            (f == aasp_pkg::FMT_SLOT) ? s : 0;
    for (int i = 0; i < 96; i++) begin
      eo[i] = 1'b0;
      eb[i] = 1'b0;
    end
    for (int k = 0; k < n; k++) begin
      pos = pulse ? base + 16 * k : ((k % 2) ? h - phA : phA) + base + 16 * (k / 2);
      c   = (f == aasp_pkg::FMT_SLOT && k < 2) ? ((k == 0) ? a : b) : k;
      for (int j = 0; j < 16; j++) begin
        eo[pos + j] = 1'b1;
        eb[pos + j] = w[c][31 - j];
      end
    end
    @(negedge clk);
    cfg = '{fmt: f, tdm: t, slotStart: s[7:0], selA: a, selB: b};
    fill();
    i_host.run(3, h, pulse);
    for (int i = 0; i < 2 * h; i++) begin
      chk(i_host.capOe[i] === eo[i], $sformatf("enable at bit %0d fmt %0d", i, f));
      if (eo[i]) chk(i_host.capBit[i] === eb[i], $sformatf("data at bit %0d fmt %0d", i, f));
    end
  endtask : check_fmt

  initial begin
    clk          = 1'b0;
    rst          = 1'b1;
    cfg          = '{fmt: aasp_pkg::FMT_RIGHT, tdm: 1'b0, slotStart: aasp_pkg::SLOT_RST,
                     selA: 2'h0, selB: 2'h1};
    wordLenM1    = 5'h0f;
    sampleIn     = '0;
    sampleValid  = 1'b0;
    error_cnt    = 0;
    total_checks = 0;
    runCnt       = 0;
    frameD       = '{ch4: 32'h7e81_1234, ch3: 32'h35ca_5678, ch2: 32'hc3a5_9abc,
                     ch1: 32'h9a3c_def0};
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    fill();
    chk(pushed == 4, "buffer depth");
    check_fmt(aasp_pkg::FMT_RIGHT, 1'b0, 0, 2'h0, 2'h1);
    check_fmt(aasp_pkg::FMT_LEFT, 1'b0, 0, 2'h0, 2'h1);
    check_fmt(aasp_pkg::FMT_I2S, 1'b0, 0, 2'h0, 2'h1);
    check_fmt(aasp_pkg::FMT_PCMA, 1'b0, 0, 2'h0, 2'h1);
    check_fmt(aasp_pkg::FMT_PCMB, 1'b0, 0, 2'h0, 2'h1);
    check_fmt(aasp_pkg::FMT_SLOT, 1'b0, 5, 2'h1, 2'h1);
    check_fmt(aasp_pkg::FMT_RIGHT, 1'b1, 0, 2'h0, 2'h1);
    check_fmt(aasp_pkg::FMT_LEFT, 1'b1, 0, 2'h0, 2'h1);
    check_fmt(aasp_pkg::FMT_I2S, 1'b1, 0, 2'h0, 2'h1);
    check_fmt(aasp_pkg::FMT_PCMA, 1'b1, 0, 2'h0, 2'h1);
    check_fmt(aasp_pkg::FMT_PCMB, 1'b1, 0, 2'h0, 2'h1);
    check_fmt(aasp_pkg::FMT_SLOT, 1'b1, 3, 2'h1, 2'h0);
    // a full buffer feeds four frames, the last two frame starts find it empty
    fill();
    runBase = runCnt;
    i_host.run(6, 48, 1'b1);
    chk(runCnt - runBase == 2, "underrun count");
    finish_test();
  end

  initial begin
    #1_500_000;
    error_cnt++;
    finish_test();
  end
endmodule : testbench
